// ---- fbsm_bank_decode.sv ----
`timescale 1ns/1ps
`default_nettype none

module fbsm_bank_decode
   import fbsm_pkg::*;
(
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic              companion_in,
   output var  fbsm_sel_t         sel_out
);

   // ---------------------------------------------------------------
   // Address to row / write / output-enable routing
   // ---------------------------------------------------------------
   always_comb begin
      if (companion_in) begin
         sel_out.in_range = 1'b1;
         sel_out.row_high = addr_in[REGION_BIT];
         sel_out.wr_bank  = addr_in[BANK_BIT];
         sel_out.oe_bank  = addr_in[BANK_BIT];
      end else begin
         // Only 4MB exists without the companion; above it only refresh strobes
         sel_out.in_range = ~addr_in[REGION_BIT];
         sel_out.row_high = addr_in[BANK_BIT];
         sel_out.wr_bank  = addr_in[BANK_BIT];
         sel_out.oe_bank  = 1'b0;
      end
   end

endmodule : fbsm_bank_decode

`default_nettype wire

// ---- fbsm_dram_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Strobe wires as the DRAM banks see them; pull-ups hold released lines high
module fbsm_dram_model
   import fbsm_pkg::*;
(
   input  wire logic        oe_in,
   input  wire logic [13:0] pins_in,
   output logic      [13:0] wire_out
);
   assign wire_out = oe_in ? pins_in : {14{STROBE_IDLE}};
endmodule : fbsm_dram_model

`default_nettype wire

// ---- fbsm_pkg.sv ----
package fbsm_pkg;

   // ---------------------------------------------------------------
   // Geometry of the 8MB strobe space
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W     = 23;
   localparam int unsigned LANES      = 8;
   localparam int unsigned BANK_BIT   = 21;
   localparam int unsigned REGION_BIT = 22;
   localparam int unsigned SYNC_W     = 3;

   // ---------------------------------------------------------------
   // Reset and idle levels of the active-low strobes
   // ---------------------------------------------------------------
   localparam logic       STROBE_IDLE = 1'b1;
   localparam logic [7:0] LANE_IDLE   = 8'hFF;
   localparam logic [1:0] PAIR_IDLE   = 2'h3;
   // Synchronisers wake as {companion, dual_we, grant} = attached, not granted, so no pin drives early
   localparam logic [2:0] SYNC_RESET  = 3'h4;

   // One access request from the memory sequencer, sampled every clock
   typedef struct packed {
      logic              row_active;
      logic              col_active;
      logic              write;
      logic              refresh;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  lane_en;
   } fbsm_req_t;

   // Bank routing decoded from an address
   typedef struct packed {
      logic in_range;
      logic row_high;
      logic wr_bank;
      logic oe_bank;
   } fbsm_sel_t;

endpackage : fbsm_pkg

// ---- fbsm_strobe_mux.sv ----
`timescale 1ns/1ps
`default_nettype none

module fbsm_strobe_mux
   import fbsm_pkg::*;
(
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic             companion_in,
   input  wire logic             dual_we_in,
   input  wire logic             grant_in,
   input  wire fbsm_req_t        req_in,
   output logic                  row_strobe_low_n_out,
   output logic                  row_strobe_high_n_out,
   output logic [LANES-1:0]      lane_strobe_n_out,
   output logic [1:0]            bank_write_strobe_n_out,
   output logic [1:0]            output_enable_n_out,
   output logic                  strobe_oe_out
);

   // ---------------------------------------------------------------
   // Pin synchronisers: straps and grant come from outside the clock
   // ---------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_d, sync1_q, sync2_d, sync2_q;
   logic              companion_q, dual_we_q, grant_q;

   always_comb begin
      sync1_d = {companion_in, dual_we_in, grant_in};
      sync2_d = sync1_q;
   end

   // Until the straps arrive the device acts ungranted, so a shared bus is never disturbed

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_q <= SYNC_RESET;
         sync2_q <= SYNC_RESET;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   assign {companion_q, dual_we_q, grant_q} = sync2_q;

   // ---------------------------------------------------------------
   // Routing
   // ---------------------------------------------------------------
   fbsm_sel_t sel;
   logic      drive;
   logic      dual_we_eff;
   logic      col_hit;

   fbsm_bank_decode u_decode (
      .addr_in      (req_in.addr),
      .companion_in (companion_q),
      .sel_out      (sel)
   );

   // Shared memory is dual-CAS only, so the strap is overridden there
   assign dual_we_eff = dual_we_q & ~companion_q;
   assign drive       = ~companion_q | grant_q;
   assign col_hit     = req_in.col_active & sel.in_range;

   function automatic logic pair_hit(input logic bank, input logic idx);
      pair_hit = (bank == idx);
   endfunction : pair_hit

   // ---------------------------------------------------------------
   // Strobe next values
   // ---------------------------------------------------------------
   logic             row_low_d, row_high_d, oe_d;
   logic [LANES-1:0] lane_d;
   logic [1:0]       wr_d, en_d;
   logic             row_low_q, row_high_q, oe_q;
   logic [LANES-1:0] lane_q;
   logic [1:0]       wr_q, en_q;

   always_comb begin
      row_low_d  = STROBE_IDLE;
      row_high_d = STROBE_IDLE;
      lane_d     = LANE_IDLE;
      wr_d       = PAIR_IDLE;
      en_d       = PAIR_IDLE;
      oe_d       = drive;
      if (drive) begin
         // Refresh of the companion's bank is its own business
         row_low_d  = ~((req_in.row_active & sel.in_range & ~sel.row_high)
                        | req_in.refresh);
         row_high_d = ~((req_in.row_active & sel.in_range & sel.row_high)
                        | (req_in.refresh & ~companion_q));
         for (int n = 0; n < LANES; n++) begin
            if (dual_we_eff)
               lane_d[n] = ~(col_hit & req_in.write & req_in.lane_en[n]);
            else
               lane_d[n] = ~(col_hit & req_in.lane_en[n]);
         end
         for (int b = 0; b < 2; b++) begin
            // In dual-WE mode the bank pins carry the per-bank column strobe
            if (dual_we_eff)
               wr_d[b] = ~(col_hit & pair_hit(sel.wr_bank, b[0]));
            else
               wr_d[b] = ~(col_hit & req_in.write & pair_hit(sel.wr_bank, b[0]));
            en_d[b] = ~(col_hit & ~req_in.write & pair_hit(sel.oe_bank, b[0]));
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         row_low_q  <= STROBE_IDLE;
         row_high_q <= STROBE_IDLE;
         lane_q     <= LANE_IDLE;
         wr_q       <= PAIR_IDLE;
         en_q       <= PAIR_IDLE;
         oe_q       <= 1'b0;
      end else begin
         row_low_q  <= row_low_d;
         row_high_q <= row_high_d;
         lane_q     <= lane_d;
         wr_q       <= wr_d;
         en_q       <= en_d;
         oe_q       <= oe_d;
      end
   end

   assign row_strobe_low_n_out    = row_low_q;
   assign row_strobe_high_n_out   = row_high_q;
   assign lane_strobe_n_out       = lane_q;
   assign bank_write_strobe_n_out = wr_q;
   assign output_enable_n_out     = en_q;
   assign strobe_oe_out           = oe_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_grant_lost;
      companion_q && grant_q ##1 !grant_q;
   endsequence

   sequence s_shared_col;
      companion_q && grant_q && req_in.col_active;
   endsequence

   sequence s_we_write;
      dual_we_eff && req_in.col_active && req_in.write && sel.in_range;
   endsequence

   a_idle_all_high: assert property (drive && !req_in.row_active && !req_in.col_active && !req_in.refresh
      |=> row_low_q && row_high_q && lane_q == LANE_IDLE && wr_q == PAIR_IDLE && en_q == PAIR_IDLE)
      else $error("strobe active with no access");
   a_bank0_row_low: assert property (!companion_q && req_in.row_active && !req_in.refresh
      && req_in.addr[REGION_BIT:BANK_BIT] == 2'h0 |=> !row_low_q && row_high_q)
      else $error("bank 0 row strobe wrong");
   a_bank1_row_high: assert property (!companion_q && req_in.row_active && !req_in.refresh
      && req_in.addr[REGION_BIT:BANK_BIT] == 2'h1 |=> row_low_q && !row_high_q)
      else $error("bank 1 row strobe wrong");
   a_shared_low_4mb: assert property (companion_q && grant_q && req_in.row_active && !req_in.addr[REGION_BIT]
      |=> !row_low_q && row_high_q)
      else $error("shared frame buffer row strobe wrong");
   a_no_high_refresh: assert property (companion_q && req_in.refresh |=> row_high_q)
      else $error("companion bank refreshed");
   a_upper_decode: assert property (companion_q && grant_q && req_in.col_active && !req_in.write
      && req_in.addr[REGION_BIT:BANK_BIT] == 2'h3 |=> en_q == 2'h1)
      else $error("6-8MB enable decode wrong");
   a_cas_lanes: assert property (!dual_we_eff && drive && req_in.col_active && sel.in_range
      |=> lane_q == ~$past(req_in.lane_en))
      else $error("column lane strobe wrong");
   a_we_lanes_read: assert property (dual_we_eff && req_in.col_active && !req_in.write
      |=> lane_q == LANE_IDLE)
      else $error("write lane strobe on read");
   a_float_no_grant: assert property (s_grant_lost |=> !oe_q [*2])
      else $error("lane strobes driven without grant");

   // ---------------------------------------------------------------
   // Bus ownership and lane mode checks
   // ---------------------------------------------------------------
   a_float_ungranted: assert property (companion_q && !grant_q
      |=> !oe_q && lane_q == LANE_IDLE)
      else $error("strobes driven while not granted");
   a_shared_cas_only: assert property (s_shared_col
      |=> lane_q == ~$past(req_in.lane_en))
      else $error("shared bus not in dual-CAS lane mode");
   a_we_lanes_write: assert property (s_we_write
      |=> lane_q == ~$past(req_in.lane_en))
      else $error("write lane strobe wrong");

   // ---------------------------------------------------------------
   // Bank decode checks
   // ---------------------------------------------------------------
   a_bank1_write: assert property (!companion_q && !dual_we_eff && req_in.col_active && req_in.write
      && req_in.addr[REGION_BIT:BANK_BIT] == 2'h1 |=> wr_q == 2'h1 && en_q == PAIR_IDLE)
      else $error("bank 1 write strobe wrong");
   a_bank_oe_shared: assert property (!companion_q && req_in.col_active && !req_in.write
      && req_in.addr[REGION_BIT:BANK_BIT] == 2'h1 |=> en_q == 2'h2)
      else $error("bank 1 read not on enable 0");
   a_fb_upper_write: assert property (companion_q && grant_q && req_in.col_active && req_in.write
      && req_in.addr[REGION_BIT:BANK_BIT] == 2'h1 |=> wr_q == 2'h1 && en_q == PAIR_IDLE)
      else $error("2-4MB write strobe wrong");
   a_refresh_both: assert property (!companion_q && req_in.refresh
      |=> !row_low_q && !row_high_q)
      else $error("refresh missed a bank");
   a_out_of_range: assert property (!companion_q && req_in.addr[REGION_BIT] && !req_in.refresh
      |=> row_low_q && row_high_q && lane_q == LANE_IDLE && wr_q == PAIR_IDLE && en_q == PAIR_IDLE)
      else $error("strobe above 4MB without companion");

endmodule : fbsm_strobe_mux

`default_nettype wire

// ---- frame_buffer_dram_strobe_mux_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module frame_buffer_dram_strobe_mux_tb
   import fbsm_pkg::*;
;
   typedef struct packed {logic [2:0] mode; fbsm_req_t req; logic [14:0] exp;} fbsm_row_t;
   logic        clock_in = 1'h0;
   logic        rst_n_in = 1'h0;
   logic        comp     = 1'h0;
   logic        dwe      = 1'h0;
   logic        gnt      = 1'h0;
   fbsm_req_t   req      = '0;
   logic        rl, rh, soe;
   logic [7:0]  lane;
   logic [1:0]  wr, oe;
   logic [13:0] pins;
   int          fails     = 0;
   int          cmp_count = 0;
   fbsm_row_t   rows[18];

   always #5 clock_in = ~clock_in;

   fbsm_strobe_mux i_fbsm_strobe_mux (.clock_in(clock_in), .rst_n_in(rst_n_in), .companion_in(comp),
      .dual_we_in(dwe), .grant_in(gnt), .req_in(req), .row_strobe_low_n_out(rl), .row_strobe_high_n_out(rh),
      .lane_strobe_n_out(lane), .bank_write_strobe_n_out(wr), .output_enable_n_out(oe), .strobe_oe_out(soe));

   fbsm_dram_model i_fbsm_dram_model (.oe_in(soe), .pins_in({rl, rh, lane, wr, oe}), .wire_out(pins));

   // Mode is {companion, dual_we, grant}; kind is {row, col, write, refresh}
   function automatic fbsm_row_t mk(input logic [2:0] m, input logic [3:0] k, input logic [22:0] a,
                                    input logic [7:0] l, input logic [14:0] e);
      mk = {m, k, a, l, e};
   endfunction : mk

   task automatic chk(input string n, input logic [14:0] s, input logic [14:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // Straps cross the synchronisers on any clock, yet each case starts from a fresh reset
   task automatic restart(input logic [2:0] m);
      @(negedge clock_in);
      rst_n_in = 1'h0;
      {comp, dwe, gnt} = m;
      req = '0;
      repeat (8) @(negedge clock_in);
      rst_n_in = 1'h1;
      // Straps are still crossing for two edges: nothing may drive yet
      repeat (2) begin
         @(negedge clock_in);
         chk("after reset", {pins, soe}, {2'h3, 8'hFF, 2'h3, 2'h3, 1'h0});
      end
      @(negedge clock_in);
   endtask : restart

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   initial begin
      rows[0]  = mk(3'h0, 4'h8, 23'h000000, 8'h00, {2'h1, 8'hFF, 2'h3, 2'h3, 1'h1});
      rows[1]  = mk(3'h0, 4'h8, 23'h200000, 8'h00, {2'h2, 8'hFF, 2'h3, 2'h3, 1'h1});
      rows[2]  = mk(3'h0, 4'h4, 23'h000000, 8'h5A, {2'h3, 8'hA5, 2'h3, 2'h2, 1'h1});
      rows[3]  = mk(3'h0, 4'h6, 23'h200000, 8'hFF, {2'h3, 8'h00, 2'h1, 2'h3, 1'h1});
      rows[4]  = mk(3'h2, 4'h6, 23'h000000, 8'h0F, {2'h3, 8'hF0, 2'h2, 2'h3, 1'h1});
      rows[5]  = mk(3'h5, 4'h8, 23'h200000, 8'h00, {2'h1, 8'hFF, 2'h3, 2'h3, 1'h1});
      rows[6]  = mk(3'h5, 4'h6, 23'h600000, 8'hFF, {2'h3, 8'h00, 2'h1, 2'h3, 1'h1});
      rows[7]  = mk(3'h5, 4'h4, 23'h400000, 8'hFF, {2'h3, 8'h00, 2'h3, 2'h2, 1'h1});
      rows[8]  = mk(3'h5, 4'h8, 23'h400000, 8'h00, {2'h2, 8'hFF, 2'h3, 2'h3, 1'h1});
      rows[9]  = mk(3'h4, 4'h4, 23'h000000, 8'hFF, {2'h3, 8'hFF, 2'h3, 2'h3, 1'h0});
      rows[10] = mk(3'h5, 4'h9, 23'h000000, 8'h00, {2'h1, 8'hFF, 2'h3, 2'h3, 1'h1});
      rows[11] = mk(3'h0, 4'h9, 23'h000000, 8'h00, {2'h0, 8'hFF, 2'h3, 2'h3, 1'h1});
      rows[12] = mk(3'h7, 4'h6, 23'h000000, 8'h0F, {2'h3, 8'hF0, 2'h2, 2'h3, 1'h1});
      rows[13] = mk(3'h0, 4'h0, 23'h000000, 8'h00, {2'h3, 8'hFF, 2'h3, 2'h3, 1'h1});
      rows[14] = mk(3'h0, 4'h8, 23'h400000, 8'h00, {2'h3, 8'hFF, 2'h3, 2'h3, 1'h1});
      rows[15] = mk(3'h2, 4'h4, 23'h200000, 8'hFF, {2'h3, 8'hFF, 2'h1, 2'h2, 1'h1});
      rows[16] = mk(3'h5, 4'h6, 23'h200000, 8'h3C, {2'h3, 8'hC3, 2'h1, 2'h3, 1'h1});
      rows[17] = mk(3'h5, 4'h4, 23'h600000, 8'hFF, {2'h3, 8'h00, 2'h3, 2'h1, 1'h1});
      for (int i = 0; i < 18; i++) begin
         restart(rows[i].mode);
         req = rows[i].req;
         @(negedge clock_in);
         chk("strobe wires", {pins, soe}, rows[i].exp);
         req = '0;
         $display("test row %0d done", i);
      end
      // Grant lost in the middle of a held column phase
      restart(3'h5);
      req = {4'h4, 23'h000000, 8'hFF};
      @(negedge clock_in);
      chk("granted read", {pins, soe}, {2'h3, 8'h00, 2'h3, 2'h2, 1'h1});
      gnt = 1'h0;
      repeat (3) @(negedge clock_in);
      chk("grant dropped", {pins, soe}, {2'h3, 8'hFF, 2'h3, 2'h3, 1'h0});
      $display("test grant drop done");
      // Reset lands while strobes are low
      gnt = 1'h1;
      repeat (4) @(negedge clock_in);
      chk("grant regained", {pins, soe}, {2'h3, 8'h00, 2'h3, 2'h2, 1'h1});
      rst_n_in = 1'h0;
      #1;
      chk("async reset", {rl, rh, lane, wr, oe, soe}, {2'h3, 8'hFF, 2'h3, 2'h3, 1'h0});
      $display("test mid reset done");
      print_verdict();
   end

   initial begin
      #100000;
      fails++;
      print_verdict();
   end
endmodule : frame_buffer_dram_strobe_mux_tb

`default_nettype wire
